// File: verilog/npe_core.sv
// Purpose: normal-mode trailing-edge pwm edge generator with register bus
// Assumes: duty input synchronous to clk_sys
// Notes: adjust b is stored but never used in this mode
`timescale 1ns/1ps
// Operation
// R1 - counter runs zero to period_limit, then wraps
// R2 - signals switch when counter equals target
// R3 - duty sets a on-time, b fills rest
// R4 - a rises at event 1
// R5 - a falls at ev1+duty+adjust a
// R6 - end-variant trigger at ev1+duty+offset
// R7 - mid-variant trigger at ev1+duty/2+offset
// R8 - b rises at a fall plus ev3-ev2
// R9 - b falls at event 4
// R10 - phase trigger from register or duty
// R11 - sample and blanking counts from registers
// R12 - adjust b ignored in normal mode
// R13 - duty and adjust a sampled at period start
module npe_core (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [15:0] filter_duty,
   output logic first_pwm_output,
   output logic second_pwm_output,
   output logic adaptive_trig,
   output logic sample_trig1,
   output logic sample_trig2,
   output logic phase_trig,
   output logic blank_a,
   output logic blank_b,
   output logic [15:0] period_count
);
   logic [2:0] ctrl_reg;
   logic [15:0] period_limit_reg;
   logic [15:0] ev1_reg, ev2_reg, ev3_reg, ev4_reg;
   logic [15:0] adj_a_reg, adj_b_reg, adpt_reg, phase_reg;
   logic [15:0] smp1_reg, smp2_reg, bla_beg_reg, bla_end_reg, blb_beg_reg, blb_end_reg;
   logic [15:0] cnt_reg;
   logic [15:0] duty_reg, adj_a_lat_reg;
   logic ack_reg;
   logic [15:0] wr16;
   logic acc;
   logic at_end;
   npe_edge_if eif();

   npe_edge_calc u_calc (
      .eif(eif)
   );

   // latched operands feed the edge calculator
   assign eif.ev1 = ev1_reg;
   assign eif.ev2 = ev2_reg;
   assign eif.ev3 = ev3_reg;
   assign eif.duty = duty_reg;
   assign eif.adj_a = adj_a_lat_reg;
   assign eif.adpt = adpt_reg;
   assign eif.mid_sel = ctrl_reg[npe_pkg::CTRL_MID_BIT];

   // one wait cycle per access so readdata comes from a flop
   assign acc = (avs_read | avs_write) & ~ack_reg;
   assign wr16 = avs_writedata[15:0];
   assign at_end = (cnt_reg >= period_limit_reg);

   // bus handshake: waitrequest drops in the cycle after the request
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= acc;
      end
   end

   // waitrequest straight from a flop; low only in the ack cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= ~acc;
      end
   end

   // register writes, whole-word only through lane 0/1 enables
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctrl_reg <= 3'h0;
         period_limit_reg <= npe_pkg::PERIOD_RST;
         ev1_reg <= 16'h0000;
         ev2_reg <= 16'h0000;
         ev3_reg <= 16'h0000;
         ev4_reg <= 16'h0000;
         adj_a_reg <= 16'h0000;
         adj_b_reg <= 16'h0000;
         adpt_reg <= 16'h0000;
         phase_reg <= 16'h0000;
         smp1_reg <= 16'h0000;
         smp2_reg <= 16'h0000;
         bla_beg_reg <= 16'h0000;
         bla_end_reg <= 16'h0000;
         blb_beg_reg <= 16'h0000;
         blb_end_reg <= 16'h0000;
      end else if (avs_write && ack_reg && avs_byteenable[1:0] == 2'h3) begin
         unique case (avs_address)
            npe_pkg::OFS_CTRL: ctrl_reg <= avs_writedata[2:0];
            npe_pkg::OFS_PERIOD: period_limit_reg <= wr16;
            npe_pkg::OFS_EV1: ev1_reg <= wr16;
            npe_pkg::OFS_EV2: ev2_reg <= wr16;
            npe_pkg::OFS_EV3: ev3_reg <= wr16;
            npe_pkg::OFS_EV4: ev4_reg <= wr16;
            npe_pkg::OFS_ADJ_A: adj_a_reg <= wr16;
            npe_pkg::OFS_ADJ_B: adj_b_reg <= wr16; // R12
            npe_pkg::OFS_ADPT: adpt_reg <= wr16;
            npe_pkg::OFS_PHASE: phase_reg <= wr16;
            npe_pkg::OFS_SMP1: smp1_reg <= wr16;
            npe_pkg::OFS_SMP2: smp2_reg <= wr16;
            npe_pkg::OFS_BLA_BEG: bla_beg_reg <= wr16;
            npe_pkg::OFS_BLA_END: bla_end_reg <= wr16;
            npe_pkg::OFS_BLB_BEG: blb_beg_reg <= wr16;
            npe_pkg::OFS_BLB_END: blb_end_reg <= wr16;
            default: ;
         endcase
      end
   end

   // read data registered; unmapped addresses return a marker word
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         avs_readdata <= 32'h00000000;
      end else if (acc && avs_read) begin
         unique case (avs_address)
            npe_pkg::OFS_CTRL: avs_readdata <= {29'h0, ctrl_reg};
            npe_pkg::OFS_PERIOD: avs_readdata <= {16'h0, period_limit_reg};
            npe_pkg::OFS_EV1: avs_readdata <= {16'h0, ev1_reg};
            npe_pkg::OFS_EV2: avs_readdata <= {16'h0, ev2_reg};
            npe_pkg::OFS_EV3: avs_readdata <= {16'h0, ev3_reg};
            npe_pkg::OFS_EV4: avs_readdata <= {16'h0, ev4_reg};
            npe_pkg::OFS_ADJ_A: avs_readdata <= {16'h0, adj_a_reg};
            npe_pkg::OFS_ADJ_B: avs_readdata <= {16'h0, adj_b_reg};
            npe_pkg::OFS_ADPT: avs_readdata <= {16'h0, adpt_reg};
            npe_pkg::OFS_PHASE: avs_readdata <= {16'h0, phase_reg};
            npe_pkg::OFS_SMP1: avs_readdata <= {16'h0, smp1_reg};
            npe_pkg::OFS_SMP2: avs_readdata <= {16'h0, smp2_reg};
            npe_pkg::OFS_BLA_BEG: avs_readdata <= {16'h0, bla_beg_reg};
            npe_pkg::OFS_BLA_END: avs_readdata <= {16'h0, bla_end_reg};
            npe_pkg::OFS_BLB_BEG: avs_readdata <= {16'h0, blb_beg_reg};
            npe_pkg::OFS_BLB_END: avs_readdata <= {16'h0, blb_end_reg};
            npe_pkg::OFS_STATUS: avs_readdata <= {16'h0, cnt_reg};
            default: avs_readdata <= npe_pkg::UNMAPPED_DATA;
         endcase
      end
   end

   // period counter; held at zero while disabled
   always_ff @(posedge clk_sys) begin
      if (rst || !ctrl_reg[npe_pkg::CTRL_EN_BIT]) begin
         cnt_reg <= npe_pkg::ZERO_CNT;
      end else if (at_end) begin
         cnt_reg <= npe_pkg::ZERO_CNT; // R1
      end else begin
         cnt_reg <= 16'(cnt_reg + npe_pkg::ONE_CNT); // R1
      end
   end

   // duty and adjust a frozen at wrap so they cannot move edges mid-period
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         duty_reg <= 16'h0000;
         adj_a_lat_reg <= 16'h0000;
      end else if (!ctrl_reg[npe_pkg::CTRL_EN_BIT] || at_end) begin
         duty_reg <= filter_duty; // R13
         adj_a_lat_reg <= adj_a_reg; // R13
      end
   end

   // output edges: set/clear on exact count match, cleared when idle
   always_ff @(posedge clk_sys) begin
      if (rst || !ctrl_reg[npe_pkg::CTRL_EN_BIT]) begin
         first_pwm_output <= 1'b0;
         second_pwm_output <= 1'b0;
      end else begin
         // fall wins if a rise and a fall land on the same count
         if (cnt_reg == eif.a_fall) begin
            first_pwm_output <= 1'b0; // R2 R3 R5
         end else if (cnt_reg == ev1_reg) begin
            first_pwm_output <= 1'b1; // R4
         end
         if (cnt_reg == ev4_reg) begin
            second_pwm_output <= 1'b0; // R9
         end else if (cnt_reg == eif.b_rise) begin
            second_pwm_output <= 1'b1; // R3 R8
         end
      end
   end

   // one-cycle triggers on count match
   always_ff @(posedge clk_sys) begin
      if (rst || !ctrl_reg[npe_pkg::CTRL_EN_BIT]) begin
         adaptive_trig <= 1'b0;
         sample_trig1 <= 1'b0;
         sample_trig2 <= 1'b0;
         phase_trig <= 1'b0;
      end else begin
         adaptive_trig <= (cnt_reg == eif.adpt_trig); // R6 R7
         sample_trig1 <= (cnt_reg == smp1_reg); // R11
         sample_trig2 <= (cnt_reg == smp2_reg); // R11
         phase_trig <= (cnt_reg == (ctrl_reg[npe_pkg::CTRL_PHSRC_BIT] ? duty_reg : phase_reg)); // R10
      end
   end

   // blanking windows from begin/end registers
   always_ff @(posedge clk_sys) begin
      if (rst || !ctrl_reg[npe_pkg::CTRL_EN_BIT]) begin
         blank_a <= 1'b0;
         blank_b <= 1'b0;
      end else begin
         if (cnt_reg == bla_end_reg) begin
            blank_a <= 1'b0; // R11
         end else if (cnt_reg == bla_beg_reg) begin
            blank_a <= 1'b1; // R11
         end
         if (cnt_reg == blb_end_reg) begin
            blank_b <= 1'b0; // R11
         end else if (cnt_reg == blb_beg_reg) begin
            blank_b <= 1'b1; // R11
         end
      end
   end

   // counter mirror for downstream sync
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         period_count <= npe_pkg::ZERO_CNT;
      end else begin
         period_count <= cnt_reg;
      end
   end
endmodule // npe_core

// File: verilog/npe_pkg.sv
// Purpose: shared constants for the normal-mode pwm edge generator
// Assumes: 32-bit avalon-mm register bus, one clock
// Notes: word offsets are byte addresses
package npe_pkg;
   localparam int CW = 16;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_PERIOD = 8'h04;
   localparam logic [7:0] OFS_EV1 = 8'h08;
   localparam logic [7:0] OFS_EV2 = 8'h0C;
   localparam logic [7:0] OFS_EV3 = 8'h10;
   localparam logic [7:0] OFS_EV4 = 8'h14;
   localparam logic [7:0] OFS_ADJ_A = 8'h18;
   localparam logic [7:0] OFS_ADJ_B = 8'h1C;
   localparam logic [7:0] OFS_ADPT = 8'h20;
   localparam logic [7:0] OFS_PHASE = 8'h24;
   localparam logic [7:0] OFS_SMP1 = 8'h28;
   localparam logic [7:0] OFS_SMP2 = 8'h2C;
   localparam logic [7:0] OFS_BLA_BEG = 8'h30;
   localparam logic [7:0] OFS_BLA_END = 8'h34;
   localparam logic [7:0] OFS_BLB_BEG = 8'h38;
   localparam logic [7:0] OFS_BLB_END = 8'h3C;
   localparam logic [7:0] OFS_STATUS = 8'h40;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_MID_BIT = 1;
   localparam int CTRL_PHSRC_BIT = 2;
   localparam logic [CW-1:0] PERIOD_RST = 16'h00FF;
   localparam logic [CW-1:0] ZERO_CNT = 16'h0000;
   localparam logic [CW-1:0] ONE_CNT = 16'h0001;
   localparam logic [31:0] UNMAPPED_DATA = 32'hDEADBEEF;
endpackage

// File: verilog/npe_edge_if.sv
// Purpose: carries latched edge operands from core to edge calculator
// Assumes: values stable for a whole period
// Notes: none
`timescale 1ns/1ps
interface npe_edge_if;
   logic [15:0] ev1;
   logic [15:0] ev2;
   logic [15:0] ev3;
   logic [15:0] duty;
   logic [15:0] adj_a;
   logic [15:0] adpt;
   logic mid_sel;
   logic [15:0] a_fall;
   logic [15:0] b_rise;
   logic [15:0] adpt_trig;
   modport core (output ev1, ev2, ev3, duty, adj_a, adpt, mid_sel, input a_fall, b_rise, adpt_trig);
   modport calc (input ev1, ev2, ev3, duty, adj_a, adpt, mid_sel, output a_fall, b_rise, adpt_trig);
endinterface

// File: verilog/npe_edge_calc.sv
// Purpose: computes the moving edge targets of normal mode
// Assumes: operands held steady across a period
// Notes: sums wrap modulo 2^16
`timescale 1ns/1ps
module npe_edge_calc (
   npe_edge_if.calc eif
);
   // a falling edge: ev1 + duty + adjust a
   assign eif.a_fall = 16'(eif.ev1 + eif.duty + eif.adj_a); // R5
   // b rise trails a fall by the ev3 - ev2 dead time
   assign eif.b_rise = 16'(eif.a_fall + 16'(eif.ev3 - eif.ev2)); // R8
   // adaptive trigger at end or middle of the on-time
   assign eif.adpt_trig = eif.mid_sel ? 16'(eif.ev1 + (eif.duty >> 1) + eif.adpt) // R7
                                      : 16'(eif.ev1 + eif.duty + eif.adpt); // R6
endmodule // npe_edge_calc

// File: sim/npe_filter_model.sv
// Purpose: feedback filter stand-in driving the duty word
// Assumes: load is a one-cycle request from the bench
// Notes: slow mode delays the new duty by three cycles
`timescale 1ns/1ps
module npe_filter_model (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic load,
   input wire logic slow,
   input wire logic [15:0] duty_in,
   output logic [15:0] filter_duty
);
   logic [15:0] pend_reg;
   logic [1:0] wait_reg;
   // a real filter settles late; slow mode holds the new duty back three cycles instead of one
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         filter_duty <= 16'h0000;
         wait_reg <= 2'h0;
      end else if (load) begin
         pend_reg <= duty_in;
         wait_reg <= slow ? 2'h3 : 2'h1;
      end else if (wait_reg != 2'h0) begin
         wait_reg <= wait_reg - 2'h1;
         if (wait_reg == 2'h1) filter_duty <= pend_reg;
      end
   end
endmodule // npe_filter_model

// File: sim/npe_core_properties.sv
// Purpose: port-level checks of the edge generator
// Assumes: registers change only through bus writes
// Notes: shadows the register file from the bus
`timescale 1ns/1ps
module npe_core_properties (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic avs_waitrequest,
   input wire logic first_pwm_output,
   input wire logic second_pwm_output,
   input wire logic adaptive_trig,
   input wire logic sample_trig1,
   input wire logic phase_trig,
   input wire logic blank_a,
   input wire logic [15:0] period_count
);
   logic [15:0] sh [0:15];
   // shadow copy; a write lands only with the low half enabled
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int i = 0; i < 16; i++) sh[i] <= 16'h0000;
         sh[1] <= npe_pkg::PERIOD_RST;
      end else if (avs_write && !avs_waitrequest && avs_byteenable[1:0] == 2'h3 && avs_address < 8'h40) begin
         sh[avs_address[5:2]] <= avs_writedata[15:0];
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_ack;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   chk_one_wait: assert property (s_req |=> s_ack) else $error("bus answer not after one wait");
   chk_cnt_wrap: assert property (period_count == sh[1] && sh[0][0] |=> period_count == 16'h0000)
      else $error("counter did not wrap at limit");
   chk_cnt_step: assert property (period_count < sh[1] && sh[0][0] && $past(sh[0][0], 3)
      |=> period_count == $past(period_count) + 16'h0001) else $error("counter did not step by one");
   chk_a_rise: assert property ($rose(first_pwm_output) |-> period_count == sh[2])
      else $error("first output rose off event one");
   chk_b_fall: assert property ($fell(second_pwm_output) |-> period_count == sh[5])
      else $error("second output fell off event four");
   chk_smp_fixed: assert property (sample_trig1 |-> period_count == sh[10])
      else $error("sample trigger off its register");
   chk_phase_reg: assert property (phase_trig && !sh[0][2] |-> period_count == sh[9])
      else $error("phase trigger off its register");
   chk_dead_gap: assert property ($rose(second_pwm_output) |-> !first_pwm_output)
      else $error("outputs overlap");
   chk_adpt_pulse: assert property (adaptive_trig |=> !adaptive_trig)
      else $error("adaptive trigger longer than a cycle");
   chk_blank_beg: assert property ($rose(blank_a) |-> period_count == sh[12])
      else $error("blanking a began off its register");
   chk_blank_end: assert property ($fell(blank_a) |-> period_count == sh[13])
      else $error("blanking a ended off its register");
endmodule // npe_core_properties
bind npe_core npe_core_properties chk_i (.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
   .avs_byteenable, .avs_waitrequest, .first_pwm_output, .second_pwm_output, .adaptive_trig, .sample_trig1,
   .phase_trig, .blank_a, .period_count);

// File: sim/tb_top.sv
// Purpose: random and corner tests of the edge generator
// Assumes: period 0xFF, events set while disabled
// Notes: duty changes mid-period must not move this period's edges
`timescale 1ns/1ps
module tb_top;
   logic clk_sys, rst, avs_read, avs_write, avs_waitrequest, load, slow, mid, psrc;
   logic first_pwm_output, second_pwm_output, adaptive_trig, sample_trig1, sample_trig2, phase_trig, blank_a, blank_b;
   logic [7:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [3:0] avs_byteenable;
   logic [15:0] filter_duty, period_count, duty_in, dcur, adj, ph;
   logic [15:0] got [0:7];
   logic [15:0] ex [0:7];
   int n_mismatch, cmp_count, cyc;
   logic [7:0] ca [0:8] = '{npe_pkg::OFS_EV1, npe_pkg::OFS_EV2, npe_pkg::OFS_EV3, npe_pkg::OFS_EV4, npe_pkg::OFS_ADPT,
      npe_pkg::OFS_SMP1, npe_pkg::OFS_SMP2, npe_pkg::OFS_BLA_BEG, npe_pkg::OFS_BLA_END};
   logic [15:0] cv [0:8] = '{16'h0010, 16'h0050, 16'h0054, 16'h00F0, 16'h0002, 16'h0030, 16'h00C0, 16'h0008, 16'h000C};
   npe_core uut (.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
      .avs_waitrequest, .filter_duty, .first_pwm_output, .second_pwm_output, .adaptive_trig, .sample_trig1,
      .sample_trig2, .phase_trig, .blank_a, .blank_b, .period_count);
   npe_filter_model filt (.clk_sys, .rst, .load, .slow, .duty_in, .filter_duty);
   task automatic cmp_val(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask
   // request held until waitrequest is sampled low
   task automatic bus_op(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      if (wr) avs_write <= 1'b1;
      else avs_read <= 1'b1;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      // let the release reach an edge before the next request
      @(posedge clk_sys);
   endtask
   // one period from count zero; chk also loads the next duty at 0x20
   task automatic measure(input logic chk, input logic [15:0] nxt);
      logic pa, pb, pl;
      pa = 1'b0;
      pb = 1'b0;
      pl = 1'b0;
      for (int k = 0; k < 8; k++) got[k] = 16'hFFFF;
      while (period_count !== 16'h0000) @(posedge clk_sys);
      repeat (256) begin
         @(posedge clk_sys);
         load <= chk && period_count == 16'h0020;
         duty_in <= nxt;
         if (first_pwm_output === 1'b1 && !pa) got[0] = period_count;
         if (first_pwm_output === 1'b0 && pa) got[1] = period_count;
         if (second_pwm_output === 1'b1 && !pb) got[2] = period_count;
         if (second_pwm_output === 1'b0 && pb) got[3] = period_count;
         if (adaptive_trig === 1'b1) got[4] = period_count;
         if (phase_trig === 1'b1) got[5] = period_count;
         if (sample_trig2 === 1'b1) got[6] = period_count;
         if (blank_a === 1'b1 && !pl) got[7] = period_count;
         pa = first_pwm_output;
         pb = second_pwm_output;
         pl = blank_a;
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // hang guard; a full run needs about 6200 cycles
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         final_report();
      end
   end
   initial begin
      {rst, avs_read, avs_write, avs_address, avs_writedata, avs_byteenable, load, slow} = '0;
      rst = 1'b1;
      duty_in = 16'h005F;
      {n_mismatch, cmp_count, cyc} = '0;
      void'($urandom(56));
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      bus_op(1'b0, npe_pkg::OFS_PERIOD, 32'h0, 4'hF);
      cmp_val("period_reset", 32'h000000FF, rd);
      bus_op(1'b0, 8'h44, 32'h0, 4'hF);
      cmp_val("unmapped", npe_pkg::UNMAPPED_DATA, rd);
      for (int k = 0; k < 9; k++) bus_op(1'b1, ca[k], {16'h0000, cv[k]}, 4'hF);
      bus_op(1'b1, npe_pkg::OFS_EV4, 32'h00000011, 4'hC);
      bus_op(1'b0, npe_pkg::OFS_EV4, 32'h0, 4'hF);
      cmp_val("ev4_partial", 32'h000000F0, rd);
      load <= 1'b1;
      @(posedge clk_sys);
      load <= 1'b0;
      dcur = 16'h005F;
      for (int it = 0; it < 8; it++) begin
         {mid, psrc} = it < 4 ? it[1:0] : 2'($urandom);
         adj = it == 0 ? 16'h0007 : 16'($urandom_range(7));
         ph = 16'h0080 + 16'($urandom_range(63));
         slow <= 1'($urandom);
         bus_op(1'b1, npe_pkg::OFS_CTRL, {29'h0, psrc, mid, 1'b1}, 4'hF);
         bus_op(1'b1, npe_pkg::OFS_ADJ_A, {16'h0000, adj}, 4'hF);
         bus_op(1'b1, npe_pkg::OFS_ADJ_B, $urandom, 4'hF);
         bus_op(1'b1, npe_pkg::OFS_PHASE, {16'h0000, ph}, 4'hF);
         measure(1'b0, dcur);
         measure(1'b1, it == 0 ? 16'h0020 : 16'h0020 + 16'($urandom_range(63)));
         ex = '{16'h0010, 16'h0010 + dcur + adj, 16'h0014 + dcur + adj, 16'h00F0,
            16'h0012 + (mid ? dcur >> 1 : dcur), psrc ? dcur : ph, 16'h00C0, 16'h0008};
         for (int k = 0; k < 8; k++) cmp_val($sformatf("edge%0d", k), {16'h0000, ex[k]}, {16'h0000, got[k]});
         dcur = duty_in;
         $display("test %0d done", it);
      end
      final_report();
   end
endmodule // tb_top
